// >>> pms_pkg.sv
// package with power-mode sequencer constants, register map and types
package pms_pkg;
    // power modes, active first, deepest last
    typedef enum logic [1:0] {
        PMS_ACTIVE,
        PMS_LIGHT,
        PMS_DEEP,
        PMS_OFF
    } pms_mode_t;

    // register byte offsets (avalon word aligned)
    localparam logic [3:0] PMS_OFS_CTRL    = 4'h0;   // mode select, sleep request, lf select
    localparam logic [3:0] PMS_OFS_STATUS  = 4'h4;   // current mode, oscillator state
    localparam logic [3:0] PMS_OFS_WAKE    = 4'h8;   // sleep timer compare value on write, sleep timer count on read
    localparam logic [3:0] PMS_OFS_WDOG    = 4'hC;   // watchdog enable / clear

    // control field positions
    localparam int PMS_CTRL_MODE_LSB = 0;            // two bits of target mode
    localparam int PMS_CTRL_REQ_BIT  = 2;            // write one: enter sleep
    localparam int PMS_CTRL_LFX_BIT  = 3;            // 1 = lf crystal, 0 = lf rc
    localparam int PMS_CTRL_HFX_BIT  = 4;            // 1 = 32 MHz crystal enabled in active
    localparam int PMS_CTRL_HFR_BIT  = 5;            // 1 = hf rc enabled in active
    localparam int PMS_WDOG_EN_BIT   = 0;            // write one: enable watchdog
    localparam int PMS_WDOG_CLR_BIT  = 1;            // write one: clear watchdog

    // control reset: lf rc, both hf sources enabled
    localparam logic [5:0] PMS_CTRL_RESET = 6'h30;
    localparam logic [31:0] PMS_WAKE_RESET = 32'h0000_8000;
    localparam logic [31:0] PMS_WDOG_LIMIT = 32'h0000_8000;  // lf ticks to watchdog expiry
endpackage

// >>> power_mode_sequencer.sv
// power-mode sequencer: mode control, oscillator and regulator gating, sleep timer, watchdog
//
// Functional notes
// - four modes: active, light, deep, off
// - active: regulator on, hf source, lf source
// - light sleep: regulator on, hf stopped, lf runs
// - light/deep wake on reset, interrupt, timer
// - deep sleep: regulator off, hf stopped, lf runs
// - off: regulator and every oscillator stopped
// - off wakes only on reset or interrupt
// - sleep timer counts lf ticks except off
// - enabled watchdog must be cleared or resets
// - pending interrupt wakes device into active first
// - resets: pin, power-on, watchdog; watchdog disabled
// - deep/off keep only retention sram half
`timescale 1ns/100ps
module power_mode_sequencer #(
    parameter int TIMER_W = 32                      // sleep timer / watchdog width
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,          // pin or power-on reset
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic                 lfTick,         // one pulse per lf oscillator period
    input  wire logic                 extIrq,         // external interrupt request level
    output logic                      coreRegOn,      // digital core regulator enable
    output logic                      hfXtalOn,       // 32 MHz crystal_oscillator enable
    output logic                      hfRcOn,         // hf rc_oscillator enable
    output logic                      lfXtalOn,       // 32.768 kHz crystal_oscillator enable
    output logic                      lfRcOn,         // 32.768 kHz rc_oscillator enable
    output logic                      sramMainOn,     // non-retention sram half powered
    output logic                      wdogReset       // pulse: watchdog resets the device
);
    ////////////////////////////////////////////////////////////////////////////////
    // state
    pms_pkg::pms_mode_t  mode, next_mode;             // current power mode
    logic [5:0]          ctrl, next_ctrl;             // control fields
    logic [TIMER_W-1:0]  sleepCount, next_sleepCount; // free running sleep timer
    logic [TIMER_W-1:0]  wakeCmp, next_wakeCmp;       // timer expiry compare
    logic                wdogEn, next_wdogEn;         // watchdog enabled
    logic [TIMER_W-1:0]  wdogCount, next_wdogCount;   // watchdog lf tick count
    logic                wdogFire, next_wdogFire;     // registered watchdog reset pulse
    logic                ackPending, next_ackPending; // one wait cycle per access
    logic [31:0]         rdData, next_rdData;         // registered read data

    logic                acc;                          // access in progress
    logic                wr;                           // write accepted this cycle
    logic                timerExpire;                  // sleep timer hit compare
    logic                sleeping;                     // any sleep mode

    assign acc             = avs_read | avs_write;
    // answer in the cycle after the request is seen: single wait state
    assign avs_waitrequest = acc & ~ackPending;
    assign wr              = avs_write & ackPending;
    assign sleeping        = (mode != pms_pkg::PMS_ACTIVE);
    assign timerExpire     = lfTick && (sleepCount == wakeCmp);

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic for bus, mode, timers
    always_comb begin
        next_ctrl       = ctrl;
        next_mode       = mode;
        next_sleepCount = sleepCount;
        next_wakeCmp    = wakeCmp;
        next_wdogEn     = wdogEn;
        next_wdogCount  = wdogCount;
        next_wdogFire   = 1'b0;
        next_ackPending = acc & ~ackPending;
        next_rdData     = rdData;

        // sleep timer stops only in off mode, where lf sources are down
        if (lfTick && mode != pms_pkg::PMS_OFF) begin
            next_sleepCount = sleepCount + 1'b1;
        end

        // register writes
        if (wr) begin
            case (avs_address)
                pms_pkg::PMS_OFS_CTRL: begin
                    next_ctrl = avs_writedata[5:0];
                    next_ctrl[pms_pkg::PMS_CTRL_REQ_BIT] = 1'b0;
                    // sleep request moves to the selected mode
                    // only taken while active: a sleeping core cannot ask, and off
                    // must never be left through a bus write
                    if (avs_writedata[pms_pkg::PMS_CTRL_REQ_BIT] && !extIrq &&
                        mode == pms_pkg::PMS_ACTIVE) begin
                        next_mode = pms_pkg::pms_mode_t'(
                            avs_writedata[pms_pkg::PMS_CTRL_MODE_LSB +: 2]);
                    end
                end
                pms_pkg::PMS_OFS_WAKE: begin
                    next_wakeCmp = avs_writedata[TIMER_W-1:0];
                end
                pms_pkg::PMS_OFS_WDOG: begin
                    // enable is sticky until reset; software cannot disable
                    if (avs_writedata[pms_pkg::PMS_WDOG_EN_BIT]) begin
                        next_wdogEn = 1'b1;
                    end
                    if (avs_writedata[pms_pkg::PMS_WDOG_CLR_BIT]) begin
                        next_wdogCount = '0;
                    end
                end
                default: begin
                    // unmapped: write ignored
                end
            endcase
        end

        // wake sources; an interrupt also overrides a same-cycle sleep request
        if (sleeping || next_mode != pms_pkg::PMS_ACTIVE) begin
            if (extIrq) begin
                next_mode = pms_pkg::PMS_ACTIVE;
            end else if (timerExpire && (mode == pms_pkg::PMS_LIGHT ||
                                         mode == pms_pkg::PMS_DEEP)) begin
                next_mode = pms_pkg::PMS_ACTIVE;
            end
        end

        // watchdog counts lf ticks; clear write wins over the tick
        if (wdogEn && lfTick && !(wr && avs_address == pms_pkg::PMS_OFS_WDOG &&
                                  avs_writedata[pms_pkg::PMS_WDOG_CLR_BIT])) begin
            if (wdogCount >= pms_pkg::PMS_WDOG_LIMIT[TIMER_W-1:0]) begin
                // timeout: reset self, back to active, watchdog disabled
                next_wdogFire  = 1'b1;
                next_wdogEn    = 1'b0;
                next_wdogCount = '0;
                next_mode      = pms_pkg::PMS_ACTIVE;
                next_ctrl      = pms_pkg::PMS_CTRL_RESET;
                next_wakeCmp   = pms_pkg::PMS_WAKE_RESET[TIMER_W-1:0];
            end else begin
                next_wdogCount = wdogCount + 1'b1;
            end
        end

        // read data: registered, unmapped reads zero
        if (avs_read && !ackPending) begin
            case (avs_address)
                pms_pkg::PMS_OFS_CTRL:   next_rdData = {26'h000_0000, ctrl};
                pms_pkg::PMS_OFS_STATUS: next_rdData = {25'h000_0000, sramMainOn, lfRcOn,
                                                         lfXtalOn, hfRcOn, hfXtalOn, mode};
                pms_pkg::PMS_OFS_WAKE:   next_rdData = 32'(sleepCount);
                pms_pkg::PMS_OFS_WDOG:   next_rdData = {31'h0000_0000, wdogEn};
                default:                 next_rdData = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers; async reset leaves watchdog disabled
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode       <= pms_pkg::PMS_ACTIVE;
            ctrl       <= pms_pkg::PMS_CTRL_RESET;
            sleepCount <= '0;
            wakeCmp    <= pms_pkg::PMS_WAKE_RESET[TIMER_W-1:0];
            wdogEn     <= 1'b0;
            wdogCount  <= '0;
            wdogFire   <= 1'b0;
            ackPending <= 1'b0;
            rdData     <= 32'h0000_0000;
        end else begin
            mode       <= next_mode;
            ctrl       <= next_ctrl;
            sleepCount <= next_sleepCount;
            wakeCmp    <= next_wakeCmp;
            wdogEn     <= next_wdogEn;
            wdogCount  <= next_wdogCount;
            wdogFire   <= next_wdogFire;
            ackPending <= next_ackPending;
            rdData     <= next_rdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // gating per mode; if both hf enables are cleared, rc is kept so active never lacks a clock
    always_comb begin
        coreRegOn  = 1'b0;
        hfXtalOn   = 1'b0;
        hfRcOn     = 1'b0;
        lfXtalOn   = 1'b0;
        lfRcOn     = 1'b0;
        sramMainOn = 1'b0;
        case (mode)
            pms_pkg::PMS_ACTIVE: begin
                coreRegOn  = 1'b1;
                hfXtalOn   = ctrl[pms_pkg::PMS_CTRL_HFX_BIT];
                hfRcOn     = ctrl[pms_pkg::PMS_CTRL_HFR_BIT] | ~ctrl[pms_pkg::PMS_CTRL_HFX_BIT];
                lfXtalOn   = ctrl[pms_pkg::PMS_CTRL_LFX_BIT];
                lfRcOn     = ~ctrl[pms_pkg::PMS_CTRL_LFX_BIT];
                sramMainOn = 1'b1;
            end
            pms_pkg::PMS_LIGHT: begin
                coreRegOn  = 1'b1;
                lfXtalOn   = ctrl[pms_pkg::PMS_CTRL_LFX_BIT];
                lfRcOn     = ~ctrl[pms_pkg::PMS_CTRL_LFX_BIT];
                sramMainOn = 1'b1;
            end
            pms_pkg::PMS_DEEP: begin
                lfXtalOn   = ctrl[pms_pkg::PMS_CTRL_LFX_BIT];
                lfRcOn     = ~ctrl[pms_pkg::PMS_CTRL_LFX_BIT];
            end
            default: begin                                    // off: all down
            end
        endcase
    end

    assign avs_readdata = rdData;
    assign wdogReset    = wdogFire;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_off_all_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode == pms_pkg::PMS_OFF |-> !(coreRegOn | hfXtalOn | hfRcOn | lfXtalOn | lfRcOn))
        else $error("off mode left something powered");
    a_deep_gating: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode == pms_pkg::PMS_DEEP |-> !coreRegOn && !hfXtalOn && !hfRcOn && (lfXtalOn ^ lfRcOn))
        else $error("deep sleep gating wrong");
    a_light_gating: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode == pms_pkg::PMS_LIGHT |-> coreRegOn && !hfXtalOn && !hfRcOn && (lfXtalOn ^ lfRcOn))
        else $error("light sleep gating wrong");
    a_active_gating: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode == pms_pkg::PMS_ACTIVE |-> coreRegOn && (hfXtalOn | hfRcOn) && (lfXtalOn ^ lfRcOn))
        else $error("active gating wrong");
    a_irq_wakes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sleeping && extIrq |=> mode == pms_pkg::PMS_ACTIVE)
        else $error("interrupt did not wake");
    a_timer_wakes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == pms_pkg::PMS_LIGHT || mode == pms_pkg::PMS_DEEP) && timerExpire
        |=> mode == pms_pkg::PMS_ACTIVE)
        else $error("timer expiry did not wake");
    a_off_no_timer: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode == pms_pkg::PMS_OFF && !extIrq && !next_wdogFire |=> mode == pms_pkg::PMS_OFF)
        else $error("off mode left without interrupt");
    a_timer_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
        mode == pms_pkg::PMS_OFF |=> sleepCount == $past(sleepCount))
        else $error("sleep timer ran in off mode");
    a_wdog_fire: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wdogFire |-> !wdogEn && mode == pms_pkg::PMS_ACTIVE)
        else $error("watchdog reset left state");
endmodule

// >>> pms_far_side.sv
// partner model: lf oscillator tick source and external interrupt line
`timescale 1ns/100ps
module pms_far_side #(
    parameter int TICK_DIV = 2       // clk periods per lf period, shortened for sim
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic lfXtalOn,
    input  wire logic lfRcOn,
    input  wire logic irqReq,        // interrupt level commanded by the bench
    output logic      lfTick,
    output logic      extIrq
);
    int divCount;                    // clk periods since the last lf edge
    //////////////////////////////////////////////////////////////////////
    // lf source only ticks while an lf oscillator is enabled
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divCount <= 0;
            lfTick   <= 1'b0;
        end else if (lfXtalOn | lfRcOn) begin
            lfTick   <= (divCount == TICK_DIV - 1);
            divCount <= (divCount == TICK_DIV - 1) ? 0 : divCount + 1;
        end else begin
            lfTick   <= 1'b0;
        end
    end
    // interrupt source is a plain level from the bench
    assign extIrq = irqReq;
endmodule

// >>> power_mode_sequencer_tb.sv
// testbench for the power-mode sequencer
`timescale 1ns/100ps
module power_mode_sequencer_tb;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        lfTick, extIrq, irqReq = 1'b0;
    logic        coreRegOn, hfXtalOn, hfRcOn, lfXtalOn, lfRcOn, sramMainOn, wdogReset;
    logic [5:0]  outs;       // regulator, hf xtal, hf rc, lf xtal, lf rc, main sram
    logic [31:0] rd, cnt;
    int          failCount = 0;
    int          checks = 0;
    int          n;
    logic [5:0]  expOut [4] = '{6'b11_1011, 6'b10_0011, 6'b00_0010, 6'b00_0000};
    logic [31:0] expStat [4] = '{32'h0000_006C, 32'h0000_0061, 32'h0000_0022, 32'h0000_0003};
    assign outs = {coreRegOn, hfXtalOn, hfRcOn, lfXtalOn, lfRcOn, sramMainOn};
    always #4 clk_sys = ~clk_sys;
    power_mode_sequencer dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lfTick(lfTick),
        .extIrq(extIrq), .coreRegOn(coreRegOn), .hfXtalOn(hfXtalOn), .hfRcOn(hfRcOn),
        .lfXtalOn(lfXtalOn), .lfRcOn(lfRcOn), .sramMainOn(sramMainOn), .wdogReset(wdogReset));
    pms_far_side far_u (.clk_sys(clk_sys), .rst_n(rst_n), .lfXtalOn(lfXtalOn),
        .lfRcOn(lfRcOn), .irqReq(irqReq), .lfTick(lfTick), .extIrq(extIrq));
    //////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic endSim;
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one avalon access; request held until waitrequest is sampled low at a rising edge
    task automatic busXfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        logic w;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            w = avs_waitrequest;
            if (w === 1'b0) begin
                rd = avs_readdata;
                break;
            end
        end
        if (n == 50) begin
            failCount++;
            endSim();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    // bounded wait for the hf clocks to come back
    task automatic waitActive(input int lim);
        for (n = 0; n < lim && outs !== expOut[0]; n++) @(negedge clk_sys);
        check("wake", outs, expOut[0]);
        if (outs !== expOut[0]) endSim();
        @(posedge clk_sys);
    endtask
    //////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        busXfer(0, pms_pkg::PMS_OFS_STATUS, 0);
        check("status reset", rd, expStat[0]);
        busXfer(0, 4'h2, 0);
        check("unmapped", rd, 32'h0000_0000);
        busXfer(0, pms_pkg::PMS_OFS_WDOG, 0);
        check("wdog at reset", rd, 32'h0000_0000);
        busXfer(1, pms_pkg::PMS_OFS_CTRL, 32'h0000_0038);
        check("lf xtal", outs, 6'b11_1101);
        busXfer(1, pms_pkg::PMS_OFS_CTRL, 32'h0000_0000);
        check("hf rc kept", outs, 6'b10_1011);
        busXfer(1, pms_pkg::PMS_OFS_CTRL, 32'h0000_0030);
        $display("test reset and select done");
        // a pending interrupt keeps the device awake
        irqReq <= 1'b1;
        busXfer(1, pms_pkg::PMS_OFS_CTRL, 32'h0000_0035);
        check("sleep refused", outs, expOut[0]);
        irqReq <= 1'b0;
        for (int m = 1; m < 4; m++) begin
            busXfer(0, pms_pkg::PMS_OFS_WAKE, 0);
            cnt = rd + 32'h0000_0014;
            busXfer(1, pms_pkg::PMS_OFS_WAKE, cnt);
            busXfer(1, pms_pkg::PMS_OFS_CTRL, 32'h0000_0034 | m);
            check("sleep outs", outs, expOut[m]);
            busXfer(0, pms_pkg::PMS_OFS_STATUS, 0);
            check("sleep status", rd, expStat[m]);
            if (m == 2) begin
                waitActive(200);
            end else begin
                if (m == 3) begin
                    busXfer(0, pms_pkg::PMS_OFS_WAKE, 0);
                    cnt = rd;
                    repeat (100) @(posedge clk_sys);
                    busXfer(0, pms_pkg::PMS_OFS_WAKE, 0);
                    check("timer frozen", rd, cnt);
                    check("off held", outs, expOut[3]);
                end
                irqReq <= 1'b1;
                waitActive(10);
                irqReq <= 1'b0;
            end
            $display("test sleep mode %0d done", m);
        end
        busXfer(1, pms_pkg::PMS_OFS_CTRL, 32'h0000_0038);
        busXfer(1, pms_pkg::PMS_OFS_WDOG, 32'h0000_0001);
        busXfer(0, pms_pkg::PMS_OFS_WDOG, 0);
        check("wdog on", rd[0], 1'b1);
        repeat (300) @(posedge clk_sys);
        busXfer(1, pms_pkg::PMS_OFS_WDOG, 32'h0000_0002);
        for (n = 0; n < 66000 && wdogReset !== 1'b1; n++) @(negedge clk_sys);
        check("wdog late", n > 65000, 1'b1);
        check("wdog fired", wdogReset, 1'b1);
        if (wdogReset !== 1'b1) endSim();
        @(posedge clk_sys);
        busXfer(0, pms_pkg::PMS_OFS_WDOG, 0);
        check("wdog cleared", rd, 32'h0000_0000);
        busXfer(0, pms_pkg::PMS_OFS_CTRL, 0);
        check("ctrl reset", rd, 32'(pms_pkg::PMS_CTRL_RESET));
        check("wdog active", outs, expOut[0]);
        $display("test watchdog done");
        endSim();
    end
endmodule
